// file: video_enh_monitor.sv
/*
 * Checker for the video enhancement datapath, watching the top ports only.
 * Assumes it is bound onto the top module and that all ports share mclk_in.
 */
module video_enh_monitor (
    input wire logic                 mclk_in,
    input wire logic                 rstn_in,
    input wire logic                 line_locked_clock_in,
    input wire logic                 rate_select_clock_input_in,
    input wire logic                 active_line_window_in,
    input wire video_enh_pkg::yuv_s  yuv_in,
    input wire logic                 scl_in,
    input wire logic                 sda_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe_out,
    input wire video_enh_pkg::pix_s  pix_out
);
    logic        llc_q_r;
    logic [43:0] act_r;
    logic        cap;

    assign cap = line_locked_clock_in && !llc_q_r && rate_select_clock_input_in;

    // Active flag of each capture, newest in bit 0
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            llc_q_r <= 1'b0;
            // Pre-filled active so the unfilled pipeline is not judged
            act_r   <= '1;
        end else begin
            llc_q_r <= line_locked_clock_in;
            if (cap) begin
                act_r <= {act_r[42:0], active_line_window_in};
            end
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    chk_reset_clear:
    assert property (disable iff (1'b0) !rstn_in |=> pix_out == '0 && !sda_oe_out) else $error("reset left outputs set");
    chk_pix_hold:
    assert property (!cap |=> $stable(pix_out)) else $error("pixel output moved outside a capture");
    chk_blank_out:
    assert property (cap && !act_r[43] |=> pix_out.u == 8'h80 && pix_out.v == 8'h80
                     && (pix_out.y == 9'h010 || pix_out.y == 9'h000)) else $error("blanked pixel not at black level");
    chk_sda_low:
    assert property (sda_out == 1'b0) else $error("data line output not low");
    chk_oe_timing:
    assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in)
                     && ($past(scl_in, 2) || $past(scl_in, 3))) else $error("data line drive moved off a clock fall");
    chk_oe_scl_high:
    assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out)) else $error("data line drive moved while clock high");
    chk_start_quiet:
    assert property (scl_in && $past(scl_in) && $fell(sda_in) |=> (!sda_oe_out) [*8]) else $error("drive right after start");
    chk_stop_release:
    assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> !sda_oe_out) else $error("drive during stop");
endmodule : video_enh_monitor

bind video_enhance_datapath_ctrl video_enh_monitor u_video_enh_monitor (
    .mclk_in                    (mclk_in),
    .rstn_in                    (rstn_in),
    .line_locked_clock_in       (line_locked_clock_in),
    .rate_select_clock_input_in (rate_select_clock_input_in),
    .active_line_window_in      (active_line_window_in),
    .yuv_in                     (yuv_in),
    .scl_in                     (scl_in),
    .sda_in                     (sda_in),
    .sda_out                    (sda_out),
    .sda_oe_out                 (sda_oe_out),
    .pix_out                    (pix_out)
);

// file: video_enh_pkg.sv
/*
 * Shared constants and carrier types for the video enhancement datapath.
 * Assumes one system clock; line clock and serial control pins arrive
 * already synchronous to it.
 */
package video_enh_pkg;
    localparam logic [6:0] DEV_ADDR        = 7'h5F;
    localparam logic [7:0] SUB_PEAK        = 8'h01;
    localparam logic [7:0] SUB_FMT         = 8'h02;
    localparam logic [7:0] SUB_IO          = 8'h03;
    localparam logic [7:0] MASK_PEAK       = 8'h7F;
    localparam logic [7:0] MASK_FMT        = 8'hE0;
    localparam logic [7:0] MASK_IO         = 8'h0F;
    localparam logic [7:0] REG_RESET       = 8'h00;
    // Field positions, peaking/coring register
    localparam int CORE_LSB = 5;
    localparam int BPS_LSB  = 3;
    localparam int BYP_BIT  = 2;
    localparam int GAIN_LSB = 0;
    // Field positions, format register
    localparam int FMT_BIT  = 7;
    localparam int IFA_BIT  = 6;
    localparam int IFB_BIT  = 5;
    // Field positions, input/output register
    localparam int CODE_BIT = 3;
    localparam int BLV_BIT  = 2;
    localparam int W8_BIT   = 1;
    localparam int INV_BIT  = 0;
    localparam logic [7:0] MSB_FLIP        = 8'h80;
    localparam logic [7:0] WIDTH7_MASK     = 8'hFE;
    localparam logic [8:0] BLACK_16        = 9'h010;
    localparam logic [8:0] BLACK_0         = 9'h000;
    localparam logic [7:0] COLOURLESS      = 8'h80;
    localparam logic signed [11:0] Y_OFFSET = 12'sh080;
    localparam logic signed [11:0] Y_MAX    = 12'sh1FF;
    localparam logic [10:0] CORE_SMALL     = 11'h002;
    localparam logic [10:0] CORE_MED       = 11'h004;
    localparam logic [10:0] CORE_HIGH      = 11'h008;
    localparam int LATENCY     = 44;
    localparam int LUMA_TAPS   = 5;
    localparam int LUMA_CENTER = 2;
    localparam int DLY_LEN     = LATENCY - LUMA_CENTER;
    localparam logic [1:0] PH_411_LAST = 2'h3;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] uv;
    } yuv_s;

    typedef struct packed {
        logic [8:0] y;
        logic [7:0] u;
        logic [7:0] v;
    } pix_s;

    typedef enum logic [3:0] {
        I_IDLE, I_ADDR, I_ADDR_ACK, I_SUB, I_SUB_ACK,
        I_WDATA, I_WDATA_ACK, I_RDATA, I_RACK
    } i2c_st_e;
endpackage : video_enh_pkg

// file: video_enhance_datapath_ctrl.sv
/*
 * Digital front end of a video enhancement processor: YUV capture, luma
 * peaking and coring, chroma interpolation, blanking and polarity, plus
 * the serial control slave holding the three setting registers.
 * Assumes all inputs are synchronous to mclk_in, and the line clock is
 * far slower than mclk_in so each of its edges is seen.
 */
// Behaviour
// - Rate select high: capture input on every line clock rising edge.
// - Half-rate reference on rate select: capture on every second rising edge.
// - Blanking forces luma code 16, or 0 when blank level select set.
// - Blanking forces both chroma codes to 128.
// - Reset returns control data to defaults, ready for fresh setup.
// - Input to output latency is 44 line clock captures.
// - Host writes start, address, subaddress, data, stop; device acks each byte.
// - Device answers address 1011111; address LSB gives direction.
// - Subaddress auto-increments after each data byte.
// - Register 01: zero, coring, bandpass select, bypass, peaking gain.
// - Register 02: format select, two filter selects, low bits zero.
// - Register 03: zeros, chroma code, blank level, input width, invert.
// - Coring threshold selects off, small, medium, high noise reduction.
// - Bandpass select picks four characteristics; bypass with 00 skips filter.
// - Gain gives 1/8..1, or 0..1 with bypass set.
// - Format and filter codes pick chroma interpolation response.
// - Chroma code select: 0 two's complement, 1 offset binary.
// - Input width select: 0 seven-bit data, 1 eight-bit data.
// - Chroma invert bit flips colour-difference output polarity.
// - Luma output nine bits wide, chroma outputs eight bits.
// - Active line low blanks luma and makes chroma colourless.
// - Luma converted to two's complement by inverting MSB.
module video_enhance_datapath_ctrl (
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 line_locked_clock_in,
    input  wire logic                 rate_select_clock_input_in,
    input  wire logic                 active_line_window_in,
    input  wire video_enh_pkg::yuv_s  yuv_in,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_out,
    output video_enh_pkg::pix_s       pix_out
);
    typedef struct packed {
        video_enh_pkg::i2c_st_e st;
        logic [2:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  tx;
        logic [7:0]  sub;
        logic        rw;
        logic        got;
        logic        nack;
        logic        drv;
        logic        scl_q;
        logic        sda_q;
        logic [7:0]  r_peak;
        logic [7:0]  r_fmt;
        logic [7:0]  r_io;
        logic        llc_q;
        logic [video_enh_pkg::LUMA_TAPS-1:0][7:0] yh;
        logic [video_enh_pkg::LUMA_CENTER:0] hh;
        logic [1:0]  ph;
        logic [7:0]  uacc;
        logic [7:0]  vacc;
        logic [7:0]  u0;
        logic [7:0]  v0;
        logic [7:0]  u1;
        logic [7:0]  v1;
        logic [7:0]  u2;
        logic [7:0]  v2;
        video_enh_pkg::pix_s [video_enh_pkg::DLY_LEN-1:0] dl;
        video_enh_pkg::pix_s outp;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    // Chroma interpolation response; wider response means less smoothing
    function automatic logic [7:0] interp(input logic [7:0] c0, input logic [7:0] c1,
                                          input logic [7:0] c2, input logic [1:0] mode);
        logic [9:0] acc;
        acc = '0;
        case (mode)
            2'b00: begin
                acc = {2'b00, c0} + {2'b00, c1};
                interp = acc[8:1];
            end
            2'b01: begin
                acc = {2'b00, c0} + {1'b0, c1, 1'b0} + {2'b00, c2};
                interp = acc[9:2];
            end
            default: begin
                interp = c0;
            end
        endcase
    endfunction : interp

    always_comb begin
        state_s n;
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic cap;
        logic [7:0] rd;
        logic [7:0] y_in;
        logic [7:0] uv_in;
        logic [7:0] u_new;
        logic [7:0] v_new;
        logic       ch_upd;
        logic signed [10:0] t0;
        logic signed [10:0] t1;
        logic signed [10:0] t2;
        logic signed [10:0] bp;
        logic signed [10:0] pk;
        logic [10:0] mag;
        logic [10:0] thr;
        logic signed [11:0] ysum;
        logic [1:0] imode;
        video_enh_pkg::pix_s px;
        n = s_r;
        scl_rise = scl_in && !s_r.scl_q;
        scl_fall = !scl_in && s_r.scl_q;
        start_c = scl_in && s_r.scl_q && s_r.sda_q && !sda_in;
        stop_c = scl_in && s_r.scl_q && !s_r.sda_q && sda_in;
        // capture only on line clock rises qualified by rate select
        cap = line_locked_clock_in && !s_r.llc_q && rate_select_clock_input_in;
        rd = '0;
        y_in = '0;
        uv_in = '0;
        u_new = '0;
        v_new = '0;
        ch_upd = 1'b0;
        t0 = '0;
        t1 = '0;
        t2 = '0;
        bp = '0;
        pk = '0;
        mag = '0;
        thr = '0;
        ysum = '0;
        imode = '0;
        px = '0;

        // Control slave
        n.scl_q = scl_in;
        n.sda_q = sda_in;
        // unmapped bits and addresses read zero
        case (s_r.sub)
            video_enh_pkg::SUB_PEAK: rd = s_r.r_peak;
            video_enh_pkg::SUB_FMT: rd = s_r.r_fmt;
            video_enh_pkg::SUB_IO: rd = s_r.r_io;
            default: rd = '0;
        endcase
        if (start_c) begin
            n.st = video_enh_pkg::I_ADDR;
            n.cnt = '0;
            n.got = 1'b0;
            n.drv = 1'b0;
        end else if (stop_c) begin
            n.st = video_enh_pkg::I_IDLE;
            n.drv = 1'b0;
        end else if (scl_rise) begin
            case (s_r.st)
                video_enh_pkg::I_ADDR, video_enh_pkg::I_SUB, video_enh_pkg::I_WDATA: begin
                    n.sh = {s_r.sh[6:0], sda_in};
                    n.cnt = s_r.cnt + 3'd1;
                    n.got = (s_r.cnt == 3'd7);
                end
                video_enh_pkg::I_RDATA: n.cnt = s_r.cnt + 3'd1;
                video_enh_pkg::I_RACK: n.nack = sda_in;
                default: n.cnt = s_r.cnt;
            endcase
        end else if (scl_fall) begin
            if (s_r.got) begin
                n.got = 1'b0;
                case (s_r.st)
                    video_enh_pkg::I_ADDR: begin
                        if (s_r.sh[7:1] == video_enh_pkg::DEV_ADDR) begin
                            n.st = video_enh_pkg::I_ADDR_ACK;
                            n.rw = s_r.sh[0];
                            n.drv = 1'b1;
                        end else begin
                            n.st = video_enh_pkg::I_IDLE;
                        end
                    end
                    video_enh_pkg::I_SUB: begin
                        n.sub = s_r.sh;
                        n.st = video_enh_pkg::I_SUB_ACK;
                        n.drv = 1'b1;
                    end
                    video_enh_pkg::I_WDATA: begin
                        case (s_r.sub)
                            video_enh_pkg::SUB_PEAK: n.r_peak = s_r.sh & video_enh_pkg::MASK_PEAK;
                            video_enh_pkg::SUB_FMT: n.r_fmt = s_r.sh & video_enh_pkg::MASK_FMT;
                            video_enh_pkg::SUB_IO: n.r_io = s_r.sh & video_enh_pkg::MASK_IO;
                            default: n.r_io = s_r.r_io;
                        endcase
                        n.sub = s_r.sub + 8'h01;
                        n.st = video_enh_pkg::I_WDATA_ACK;
                        n.drv = 1'b1;
                    end
                    default: n.st = video_enh_pkg::I_IDLE;
                endcase
            end else begin
                case (s_r.st)
                    video_enh_pkg::I_ADDR_ACK: begin
                        n.cnt = '0;
                        if (s_r.rw) begin
                            n.tx = rd;
                            n.drv = !rd[7];
                            n.st = video_enh_pkg::I_RDATA;
                        end else begin
                            n.drv = 1'b0;
                            n.st = video_enh_pkg::I_SUB;
                        end
                    end
                    video_enh_pkg::I_SUB_ACK, video_enh_pkg::I_WDATA_ACK: begin
                        n.drv = 1'b0;
                        n.cnt = '0;
                        n.st = video_enh_pkg::I_WDATA;
                    end
                    video_enh_pkg::I_RDATA: begin
                        if (s_r.cnt == 3'd0) begin
                            n.drv = 1'b0;
                            n.sub = s_r.sub + 8'h01;
                            n.st = video_enh_pkg::I_RACK;
                        end else begin
                            n.tx = {s_r.tx[6:0], 1'b0};
                            n.drv = !s_r.tx[6];
                        end
                    end
                    video_enh_pkg::I_RACK: begin
                        if (s_r.nack) begin
                            n.st = video_enh_pkg::I_IDLE;
                        end else begin
                            n.tx = rd;
                            n.drv = !rd[7];
                            n.cnt = '0;
                            n.st = video_enh_pkg::I_RDATA;
                        end
                    end
                    default: n.drv = 1'b0;
                endcase
            end
        end

        n.llc_q = line_locked_clock_in;

        if (cap) begin
            y_in = s_r.r_io[video_enh_pkg::W8_BIT] ? yuv_in.y : (yuv_in.y & video_enh_pkg::WIDTH7_MASK);
            uv_in = s_r.r_io[video_enh_pkg::W8_BIT] ? yuv_in.uv : (yuv_in.uv & video_enh_pkg::WIDTH7_MASK);
            n.yh = {s_r.yh[video_enh_pkg::LUMA_TAPS-2:0], y_in ^ video_enh_pkg::MSB_FLIP};
            n.hh = {s_r.hh[video_enh_pkg::LUMA_CENTER-1:0], active_line_window_in};

            // Chroma demultiplex; phase restarts each inactive sample
            n.ph = active_line_window_in ? s_r.ph + 2'd1 : 2'd0;
            if (s_r.r_fmt[video_enh_pkg::FMT_BIT]) begin
                if (!s_r.ph[0]) begin
                    n.uacc = uv_in;
                end else begin
                    u_new = s_r.uacc;
                    v_new = uv_in;
                    ch_upd = 1'b1;
                end
            end else begin
                n.uacc = {s_r.uacc[5:0], uv_in[7:6]};
                n.vacc = {s_r.vacc[5:0], uv_in[5:4]};
                u_new = n.uacc;
                v_new = n.vacc;
                ch_upd = (s_r.ph == video_enh_pkg::PH_411_LAST);
            end
            if (ch_upd) begin
                // two's complement input converted to offset binary
                n.u0 = s_r.r_io[video_enh_pkg::CODE_BIT] ? u_new : (u_new ^ video_enh_pkg::MSB_FLIP);
                n.v0 = s_r.r_io[video_enh_pkg::CODE_BIT] ? v_new : (v_new ^ video_enh_pkg::MSB_FLIP);
                n.u1 = s_r.u0;
                n.v1 = s_r.v0;
                n.u2 = s_r.u1;
                n.v2 = s_r.v1;
            end

            // bandpass: tap spacing and scale per select, bypass is plain difference
            t0 = 11'(signed'(s_r.r_peak[video_enh_pkg::BPS_LSB] ? n.yh[4] : n.yh[3]));
            t2 = 11'(signed'(s_r.r_peak[video_enh_pkg::BPS_LSB] ? n.yh[0] : n.yh[1]));
            t1 = 11'(signed'(n.yh[video_enh_pkg::LUMA_CENTER]));
            if (s_r.r_peak[video_enh_pkg::BYP_BIT]) begin
                bp = t1 - t2;
            end else if (s_r.r_peak[video_enh_pkg::BPS_LSB+1]) begin
                bp = ((t1 <<< 1) - t0 - t2) >>> 1;
            end else begin
                bp = ((t1 <<< 1) - t0 - t2) >>> 2;
            end
            mag = bp[10] ? 11'(-bp) : bp;
            case (s_r.r_peak[video_enh_pkg::CORE_LSB +: 2])
                2'b01: thr = video_enh_pkg::CORE_SMALL;
                2'b10: thr = video_enh_pkg::CORE_MED;
                2'b11: thr = video_enh_pkg::CORE_HIGH;
                default: thr = '0;
            endcase
            if (mag <= thr) begin
                bp = '0;
            end
            case (s_r.r_peak[video_enh_pkg::GAIN_LSB +: 2])
                2'b00: pk = s_r.r_peak[video_enh_pkg::BYP_BIT] ? 11'sd0 : (bp >>> 3);
                2'b01: pk = bp >>> 2;
                2'b10: pk = bp >>> 1;
                default: pk = bp;
            endcase
            ysum = 12'(t1) + 12'(pk) + video_enh_pkg::Y_OFFSET;
            if (ysum < 12'sd0) begin
                px.y = '0;
            end else if (ysum > video_enh_pkg::Y_MAX) begin
                px.y = video_enh_pkg::Y_MAX[8:0];
            end else begin
                px.y = ysum[8:0];
            end
            // interpolation response from format and filter bits
            imode = {s_r.r_fmt[video_enh_pkg::IFA_BIT],
                     s_r.r_fmt[video_enh_pkg::IFB_BIT] && !s_r.r_fmt[video_enh_pkg::IFA_BIT]};
            if (!s_r.r_fmt[video_enh_pkg::FMT_BIT] && s_r.r_fmt[video_enh_pkg::IFA_BIT]) begin
                imode = 2'b00;
            end
            px.u = interp(n.u0, n.u1, n.u2, imode);
            px.v = interp(n.v0, n.v1, n.v2, imode);
            if (s_r.r_io[video_enh_pkg::INV_BIT]) begin
                px.u = ~px.u;
                px.v = ~px.v;
            end
            if (!n.hh[video_enh_pkg::LUMA_CENTER]) begin
                px.y = s_r.r_io[video_enh_pkg::BLV_BIT] ? video_enh_pkg::BLACK_0 : video_enh_pkg::BLACK_16;
                px.u = video_enh_pkg::COLOURLESS;
                px.v = video_enh_pkg::COLOURLESS;
            end
            // delay line sized for the total latency less the luma centre tap delay
            n.dl = {s_r.dl[video_enh_pkg::DLY_LEN-2:0], px};
            n.outp = s_r.dl[video_enh_pkg::DLY_LEN-1];
        end
        s_nxt = n;
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            s_r <= '0;
            s_r.r_peak <= video_enh_pkg::REG_RESET;
            s_r.r_fmt <= video_enh_pkg::REG_RESET;
            s_r.r_io <= video_enh_pkg::REG_RESET;
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = s_r.drv;
    assign pix_out = s_r.outp;
endmodule : video_enhance_datapath_ctrl

// file: video_enhance_datapath_ctrl_test.sv
/*
 * Self-checking bench: serial register host tasks plus video stream tests.
 * Assumes the source model supplies line clock and rate qualifier.
 */
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module video_enhance_datapath_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                mclk_in = 1'b0;
    logic                rstn_in = 1'b0;
    logic                act     = 1'b0;
    logic                half    = 1'b0;
    logic                scl     = 1'b1;
    logic                sda_drv = 1'b1;
    video_enh_pkg::yuv_s yuv     = '0;
    video_enh_pkg::pix_s pix;
    logic                line_locked_clock;
    logic                rate;
    logic                sda_o;
    logic                sda_oe;
    logic                sda_w;
    int                  mismatches   = 0;
    int                  total_checks = 0;
    localparam logic [7:0] TAB [5][3] = '{'{8'h0E, 8'h00, 8'h00}, '{8'h0F, 8'h00, 8'hFF},
        '{8'h06, 8'h00, 8'h80}, '{8'h06, 8'h80, 8'h00}, '{8'h0C, 8'h01, 8'h00}};

    // Open-drain wire: low when the device enables its low output
    assign sda_w = sda_drv & (sda_oe ? sda_o : 1'b1);

    video_src_model u_video_src_model (.mclk_in(mclk_in), .half_in(half), .llc_out(line_locked_clock), .rate_out(rate));
    video_enhance_datapath_ctrl u_video_enhance_datapath_ctrl (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .line_locked_clock_in(line_locked_clock), .rate_select_clock_input_in(rate),
        .active_line_window_in(act), .yuv_in(yuv), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .pix_out(pix));

    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc
    task automatic bw(input logic b);
        sda_drv <= b;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        scl <= 1'b0;
        cyc(2);
    endtask : bw
    task automatic br(output logic b);
        sda_drv <= 1'b1;
        cyc(2);
        scl <= 1'b1;
        cyc(2);
        b = sda_w;
        cyc(2);
        scl <= 1'b0;
        cyc(2);
    endtask : br
    task automatic start();
        cyc(4);
        sda_drv <= 1'b0;
        cyc(4);
        scl <= 1'b0;
        cyc(2);
    endtask : start
    task automatic stop();
        sda_drv <= 1'b0;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        sda_drv <= 1'b1;
        cyc(4);
    endtask : stop
    task automatic wb(input logic [7:0] d, input logic ack_exp);
        logic a;
        for (int i = 7; i >= 0; i--) bw(d[i]);
        br(a);
        `CHK(a, ~ack_exp)
    endtask : wb
    task automatic reg_wr(input logic [7:0] sub, input logic [7:0] d[$]);
        start();
        wb({video_enh_pkg::DEV_ADDR, 1'b0}, 1'b1);
        wb(sub, 1'b1);
        foreach (d[k]) wb(d[k], 1'b1);
        stop();
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] e[$]);
        logic [7:0] r;
        logic       b;
        start();
        wb({video_enh_pkg::DEV_ADDR, 1'b1}, 1'b1);
        foreach (e[k]) begin
            for (int i = 7; i >= 0; i--) begin
                br(b);
                r[i] = b;
            end
            bw(k == e.size() - 1);
            `CHK(r, e[k])
        end
        stop();
    endtask : reg_rd
    // Captures and line clock rises from first active capture to output change
    task automatic lat(input logic h, input int rises);
        int   n;
        int   r;
        logic q;
        n = 0;
        r = 0;
        q = 1'b1;
        half <= h;
        act  <= 1'b0;
        cyc(600);
        `CHK(pix.y, 9'h000)
        act <= 1'b1;
        repeat (3000) begin
            @(negedge mclk_in);
            if (pix.y !== 9'h000) break;
            if (line_locked_clock && !q && act) begin
                if (rate) n++;
                if (n > 0) r++;
            end
            q = line_locked_clock;
        end
        cyc(1);
        `CHK(n, 45)
        `CHK(r, rises)
    endtask : lat
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    initial begin
        #200_000;
        mismatches++;
        test_done();
    end

    initial begin
        cyc(6);
        rstn_in <= 1'b1;
        cyc(2);
        reg_wr(8'h00, '{8'h00});
        reg_rd('{8'h00, 8'h00, 8'h00});
        reg_wr(8'h01, '{8'hFF, 8'hFF, 8'hFF});
        reg_wr(8'h00, '{8'h00});
        reg_rd('{8'h7F, 8'hE0, 8'h0F});
        start();
        wb({7'h5E, 1'b0}, 1'b0);
        stop();
        $display("registers done");
        reg_wr(8'h01, '{8'h04, 8'h80, 8'h0A});
        cyc(400);
        `CHK(pix.y, 9'h010)
        `CHK(pix.u, 8'h80)
        `CHK(pix.v, 8'h80)
        $display("blanking done");
        yuv <= '{y: 8'hFF, uv: 8'h00};
        reg_wr(8'h03, '{8'h0E});
        lat(1'b0, 45);
        lat(1'b1, 89);
        half <= 1'b0;
        $display("latency done");
        for (int i = 0; i < 5; i++) begin
            yuv.uv <= TAB[i][1];
            reg_wr(8'h03, '{TAB[i][0]});
            cyc(300);
            `CHK(pix.u, TAB[i][2])
            `CHK(pix.v, TAB[i][2])
        end
        $display("chroma done");
        // Flat input: no detail to peak, constant chroma in every format
        yuv.uv <= 8'h00;
        for (int i = 0; i < 8; i++) begin
            reg_wr(8'h01, '{(i < 4) ? 8'(i * 8'h29) : 8'(8'h04 + i - 4), 8'(i * 8'h20), 8'h0E});
            act <= 1'b1;
            cyc(300);
            `CHK(pix.y, 9'h0FF)
            `CHK(pix.u, 8'h00)
            `CHK(pix.v, 8'h00)
            act <= 1'b0;
            cyc(300);
            `CHK(pix.y, 9'h000)
        end
        $display("modes done");
        test_done();
    end
endmodule : video_enhance_datapath_ctrl_test

// file: video_src_model.sv
/*
 * Upstream video source: free-running line clock and rate qualifier.
 * Assumes mclk_in is the system clock; pixel words come from the bench.
 */
module video_src_model (
    input  wire logic mclk_in,
    input  wire logic half_in,
    output logic      llc_out,
    output logic      rate_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_r = 3'h0;

    // Line clock two cycles high, two low; runs free like a video clock
    always @(posedge mclk_in) begin
        cnt_r <= cnt_r + 3'h1;
    end
    assign llc_out = cnt_r[1];
    assign rate_out = half_in ? cnt_r[2] : 1'b1;
endmodule : video_src_model
